// [pkg/irf_pkg.sv]
package irf_pkg;

    // ------------------------------------------------------------
    // Timing, counter and speed widths, speed count
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned REPLY_DEADLINE_MS = 300;
    localparam int unsigned REPLY_DEADLINE_CYC = REPLY_DEADLINE_MS * (CLK_HZ / 1000);
    localparam int unsigned RETRY_INTERVAL_MIN_MS = 500;
    localparam int unsigned RETRY_INTERVAL_MIN_CYC = RETRY_INTERVAL_MIN_MS * (CLK_HZ / 1000);
    localparam int unsigned CNT_W = 24;
    localparam int unsigned SPD_W = 3;
    localparam int unsigned NUM_SPEEDS_DEF = 2;

    // ------------------------------------------------------------
    // Notification result codes
    // ------------------------------------------------------------
    localparam logic [7:0] RES_SUPPORTED = 8'h00;
    localparam logic [7:0] RES_NOT_SUPPORTED = 8'h01;
    localparam logic [7:0] RES_SPEED_ONLY = 8'h02;

    // State code shown on the status output
    typedef enum logic [2:0] {
        ST_UNRECOGNIZED,
        ST_WAIT_REPLY,
        ST_WAIT_ACCEPT,
        ST_NO_CONNECT,
        ST_UNCONFIRMED,
        ST_CONFIRMED
    } irf_state_t;

    // Interface data response from the equipment
    typedef struct packed {
        logic valid;
        logic usable;
    } irf_resp_t;

    // Recognition notification to the equipment
    typedef struct packed {
        logic valid;
        logic [7:0] result;
    } irf_note_t;

endpackage

// [logic/irf_fsm.sv]
`timescale 1ns/1ps
module irf_fsm
    import irf_pkg::*;
#(
    parameter int unsigned NUM_SPEEDS = NUM_SPEEDS_DEF,
    parameter logic [CNT_W-1:0] RETRY_CYC = CNT_W'(RETRY_INTERVAL_MIN_CYC),
    parameter logic [CNT_W-1:0] DEADLINE_CYC = CNT_W'(REPLY_DEADLINE_CYC),
    parameter bit START_RECOGNIZED = 1'b0,
    parameter bit RECONFIRM_ON_FAIL = 1'b1
)(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire irf_resp_t resp_i,
    input wire logic accept_i,
    input wire logic confirm_ok_i,
    input wire logic comm_fail_i,
    input wire logic recover_fail_i,
    output logic req_o,
    output logic [SPD_W-1:0] speed_o,
    output irf_note_t note_o,
    output logic confirm_start_o,
    output logic recover_start_o,
    output logic abort_o,
    output irf_state_t state_o,
    output logic no_connect_o
);

    // ------------------------------------------------------------
    // State and counters
    // ------------------------------------------------------------
    irf_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [SPD_W-1:0] spd_q, spd_d;
    logic recov_q, recov_d;
    irf_note_t note_q, note_d;
    logic req_q, req_d;
    logic conf_q, conf_d;
    logic rec_q, rec_d;
    logic abort_q, abort_d;
    logic nc_q;

    // ------------------------------------------------------------
    // Decodes
    // ------------------------------------------------------------
    // Counter and speed selection
    wire cnt_zero = (cnt_q == '0);
    wire [CNT_W-1:0] cnt_dec = cnt_zero ? cnt_q : cnt_q - CNT_W'(1);
    wire last_spd = (spd_q == SPD_W'(NUM_SPEEDS - 1));
    wire [SPD_W-1:0] spd_next = last_spd ? '0 : spd_q + SPD_W'(1);
    wire irf_state_t start_state = START_RECOGNIZED ? ST_UNCONFIRMED : ST_UNRECOGNIZED;

    // Events that matter only once recognised
    wire in_recog = (state_q == ST_UNCONFIRMED) || (state_q == ST_CONFIRMED);
    wire give_up = in_recog && recover_fail_i && recov_q;
    wire fail_seen = in_recog && comm_fail_i;
    wire confirm_done = (state_q == ST_UNCONFIRMED) && confirm_ok_i;

    // Flag follows the state being entered
    wire nc_next = (state_d == ST_NO_CONNECT);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Defaults hold the state and drop every pulse
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_dec;
        spd_d = spd_q;
        recov_d = recov_q;
        note_d = '0;
        req_d = 1'b0;
        conf_d = 1'b0;
        rec_d = 1'b0;
        abort_d = 1'b0;
        case (state_q)
            ST_UNRECOGNIZED:
            begin
                // Request goes out and the reply window opens
                if (cnt_zero)
                begin
                    req_d = 1'b1;
                    cnt_d = RETRY_CYC;
                    state_d = ST_WAIT_REPLY;
                end
            end
            ST_WAIT_REPLY:
            begin
                if (resp_i.valid)
                begin
                    note_d.valid = 1'b1;
                    if (resp_i.usable)
                    begin
                        note_d.result = RES_SUPPORTED;
                        cnt_d = DEADLINE_CYC;
                        state_d = ST_WAIT_ACCEPT;
                    end
                    else
                    begin
                        note_d.result = RES_NOT_SUPPORTED;
                        abort_d = 1'b1;
                        state_d = ST_NO_CONNECT;
                    end
                end
                else if (cnt_zero)
                begin
                    spd_d = spd_next;
                    state_d = ST_UNRECOGNIZED;
                end
            end
            ST_WAIT_ACCEPT:
            begin
                if (accept_i)
                begin
                    conf_d = 1'b1;
                    recov_d = 1'b0;
                    state_d = ST_UNCONFIRMED;
                end
                else if (cnt_zero)
                begin
                    // Deadline missed: start over with a new request
                    state_d = ST_UNRECOGNIZED;
                end
            end
            ST_NO_CONNECT:
            begin
                // Left only by reset; no method suits both sides
                state_d = ST_NO_CONNECT;
            end
            ST_UNCONFIRMED, ST_CONFIRMED:
            begin
                // A failed recovery outranks a fresh failure
                if (give_up)
                begin
                    cnt_d = '0;
                    state_d = ST_UNRECOGNIZED;
                end
                else if (fail_seen)
                begin
                    rec_d = 1'b1;
                    recov_d = 1'b1;
                    conf_d = RECONFIRM_ON_FAIL;
                    if (RECONFIRM_ON_FAIL)
                    begin
                        state_d = ST_UNCONFIRMED;
                    end
                end
                else if (confirm_done)
                begin
                    recov_d = 1'b0;
                    state_d = ST_CONFIRMED;
                end
            end
            default:
            begin
                state_d = ST_UNRECOGNIZED;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    // Synchronous reset loads the power-on state
    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            state_q <= start_state;
            cnt_q <= '0;
            spd_q <= '0;
            recov_q <= 1'b0;
            note_q <= '0;
            req_q <= 1'b0;
            conf_q <= START_RECOGNIZED;
            rec_q <= 1'b0;
            abort_q <= 1'b0;
            nc_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            spd_q <= spd_d;
            recov_q <= recov_d;
            note_q <= note_d;
            req_q <= req_d;
            conf_q <= conf_d;
            rec_q <= rec_d;
            abort_q <= abort_d;
            nc_q <= nc_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Every output comes straight from a flop
    assign req_o = req_q;
    assign speed_o = spd_q;
    assign note_o = note_q;
    assign confirm_start_o = conf_q;
    assign recover_start_o = rec_q;
    assign abort_o = abort_q;
    assign state_o = state_q;
    assign no_connect_o = nc_q;

endmodule

// [tb/irf_fsm_sva.sv]
`timescale 1ns/1ps
module irf_fsm_sva
    import irf_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire irf_resp_t resp_i,
    input wire logic accept_i,
    input wire logic confirm_ok_i,
    input wire logic comm_fail_i,
    input wire logic req_o,
    input wire irf_note_t note_o,
    input wire logic confirm_start_o,
    input wire logic recover_start_o,
    input wire logic abort_o,
    input wire irf_state_t state_o,
    input wire logic no_connect_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic in_wr = state_o == ST_WAIT_REPLY && resp_i.valid;
    req_start_a: assert property (
        state_o == ST_UNRECOGNIZED |=> req_o && state_o == ST_WAIT_REPLY) else $error("no req");
    note_ok_a: assert property (
        in_wr && resp_i.usable |=> note_o == {1'b1, RES_SUPPORTED}) else $error("bad note");
    note_bad_a: assert property (
        in_wr && !resp_i.usable |=> note_o.result == RES_NOT_SUPPORTED) else $error("bad note");
    abort_entry_a: assert property (
        in_wr && !resp_i.usable |=> abort_o && no_connect_o) else $error("no abort");
    stay_noconn_a: assert property (
        state_o == ST_NO_CONNECT |=> no_connect_o && state_o == ST_NO_CONNECT) else $error("left");
    accept_go_a: assert property (
        state_o == ST_WAIT_ACCEPT && accept_i |=> confirm_start_o) else $error("no confirm");
    confirm_go_a: assert property (
        state_o == ST_UNCONFIRMED && confirm_ok_i |=> state_o == ST_CONFIRMED) else $error("stuck");
    fail_recover_a: assert property (
        state_o == ST_CONFIRMED && comm_fail_i |=> recover_start_o) else $error("no recovery");
    reply_limit_a: assert property (
        $rose(state_o == ST_WAIT_ACCEPT) |-> ##[1:12] state_o != ST_WAIT_ACCEPT) else $error("hang");
endmodule
bind irf_fsm irf_fsm_sva u_sva (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .resp_i(resp_i),
    .accept_i(accept_i), .confirm_ok_i(confirm_ok_i), .comm_fail_i(comm_fail_i), .req_o(req_o),
    .note_o(note_o), .confirm_start_o(confirm_start_o), .recover_start_o(recover_start_o),
    .abort_o(abort_o),
    .state_o(state_o), .no_connect_o(no_connect_o));

// [tb/irf_equip_model.sv]
`timescale 1ns/1ps
module irf_equip_model
    import irf_pkg::*;
(
    input wire logic mclk_i,
    input wire logic req_i,
    input wire irf_note_t note_i,
    input wire logic usable_i,
    input wire logic mute_i,
    input wire logic hold_i,
    input wire logic [3:0] dly_i,
    output irf_resp_t resp_o = '0,
    output logic accept_o = 1'b0
);
    // Answer a request after dly_i cycles
    always @(posedge mclk_i)
        if (req_i && !mute_i)
        begin
            repeat (dly_i) @(posedge mclk_i);
            resp_o <= '{1'b1, usable_i};
            @(posedge mclk_i) resp_o <= '0;
        end
    // Accept only a favourable note; else back to waiting
    always @(posedge mclk_i)
        if (note_i.valid && note_i.result == RES_SUPPORTED && !hold_i)
        begin
            repeat (dly_i) @(posedge mclk_i);
            accept_o <= 1'b1;
            @(posedge mclk_i) accept_o <= 1'b0;
        end
endmodule

// [tb/interface_recognition_fsm_tb.sv]
`timescale 1ns/1ps
module interface_recognition_fsm_tb
    import irf_pkg::*;
;
    logic mclk = 0, rst_n = 0, ok = 0, fl = 0, rf = 0, use_m = 1, mute = 0, hold = 0, accept;
    logic req, cs, rs, nc, abort, cs2, rs2;
    logic [3:0] dly = '0;
    logic [2:0] spd;
    irf_resp_t resp;
    irf_note_t note;
    irf_state_t st, st2;
    int fail_count = 0, num_checks = 0;
    initial forever #50 mclk = ~mclk;
    irf_fsm #(.RETRY_CYC(24'h14), .DEADLINE_CYC(24'ha)) i_dut (.mclk_i(mclk), .rst_n_i(rst_n),
        .resp_i(resp), .accept_i(accept), .confirm_ok_i(ok), .comm_fail_i(fl), .recover_fail_i(rf),
        .req_o(req), .speed_o(spd), .note_o(note), .confirm_start_o(cs), .recover_start_o(rs),
        .abort_o(abort), .state_o(st), .no_connect_o(nc));
    irf_fsm #(.RETRY_CYC(24'h14), .DEADLINE_CYC(24'ha), .START_RECOGNIZED(1'b1),
        .RECONFIRM_ON_FAIL(1'b0)) i_dut_alt (.mclk_i(mclk), .rst_n_i(rst_n), .resp_i(resp),
        .accept_i(accept), .confirm_ok_i(ok), .comm_fail_i(fl), .recover_fail_i(rf), .req_o(),
        .speed_o(), .note_o(), .confirm_start_o(cs2), .recover_start_o(rs2), .abort_o(),
        .state_o(st2), .no_connect_o());
    irf_equip_model i_eq (.mclk_i(mclk), .req_i(req), .note_i(note), .usable_i(use_m),
        .mute_i(mute), .hold_i(hold), .dly_i(dly), .resp_o(resp), .accept_o(accept));
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (fail_count == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wait_st(input irf_state_t s);
        int n = 0;
        while (st !== s && n < 400)
        begin
            @(negedge mclk);
            n++;
        end
        chk(9'(st), 9'(s));
        if (st !== s)
            tally_and_finish;
    endtask
    task automatic t_recog;
        wait_st(ST_WAIT_ACCEPT);
        chk(note, {1'b1, RES_SUPPORTED});
        wait_st(ST_UNCONFIRMED);
        chk(9'(cs), 9'h1);
        @(negedge mclk) ok = 1;
        @(negedge mclk) ok = 0;
        chk(9'(st), 9'(ST_CONFIRMED));
    endtask
    task automatic t_fail;
        @(negedge mclk) fl = 1;
        @(negedge mclk) fl = 0;
        chk({rs, cs, 4'h0, st}, {6'h30, ST_UNCONFIRMED});
        chk({rs2, cs2, 4'h0, st2}, {6'h20, ST_CONFIRMED});
        @(negedge mclk) rf = 1;
        @(negedge mclk) rf = 0;
        chk(9'(st), 9'(ST_UNRECOGNIZED));
        @(negedge mclk) chk(9'(req), 9'h1);
    endtask
    task automatic t_deadline;
        int n = 0;
        wait_st(ST_WAIT_ACCEPT);
        while (!req && n < 20)
            @(negedge mclk) n++;
        chk(9'(n >= 10 && n <= 13), 9'h1);
        if (!req)
            tally_and_finish;
    endtask
    task automatic t_retry;
        logic [2:0] s[3];
        int n;
        mute = 1;
        hold = 0;
        for (int k = 0; k < 3; k++)
        begin
            n = 0;
            @(negedge mclk);
            while (!req && n < 200)
                @(negedge mclk) n++;
            chk(9'(req), 9'h1);
            if (!req)
                tally_and_finish;
            s[k] = spd;
        end
        chk(9'(s[1]), 9'((s[0] + 1) % NUM_SPEEDS_DEF));
        chk(9'(s[2]), 9'(s[0]));
        mute = 0;
        use_m = 0;
    endtask
    initial
    begin
        repeat (16) @(negedge mclk);
        rst_n = 1;
        chk({cs2, 5'h0, st2}, {6'h20, ST_UNCONFIRMED});
        t_recog;
        t_fail;
        dly = 4'h7;
        t_recog;
        t_fail;
        hold = 1;
        t_deadline;
        t_retry;
        wait_st(ST_NO_CONNECT);
        chk(note, {1'b1, RES_NOT_SUPPORTED});
        chk(9'(abort), 9'h1);
        repeat (30) @(negedge mclk);
        chk({nc, 5'h0, st}, {6'h20, ST_NO_CONNECT});
        tally_and_finish;
    end
endmodule
